// ==== design/npcd_pkg.sv ====
// package for the nonvolatile-memory program clock divider
package npcd_pkg;
  localparam int unsigned addr_width = 4;
  localparam logic [3:0] cfg_offset = 4'h0;
  localparam logic [3:0] cmd_offset = 4'h1;
  localparam logic [3:0] stat_offset = 4'h2;
  localparam logic [3:0] len_offset = 4'h3;
  localparam int unsigned loaded_pos = 7;
  localparam int unsigned prescale_pos = 6;
  localparam logic [7:0] cfg_reset = 8'h00;
  localparam logic [5:0] div_reset = 6'h00;
  localparam logic [7:0] len_reset = 8'h04;
  localparam logic [2:0] prescale_last = 3'h7;
  localparam int unsigned clock_khz = 10000;
  // status bits
  localparam int unsigned done_pos = 0;
  localparam int unsigned empty_pos = 1;
  localparam int unsigned pump_pos = 2;
  localparam int unsigned refused_pos = 3;
  localparam int unsigned burst_pos = 4;
  // command register: bit 7 launches (clears buffer-empty), bit 0 burst
  localparam int unsigned launch_pos = 7;
  localparam int unsigned cmd_burst_pos = 0;
  typedef enum logic [1:0] {
    npcd_idle = 2'b00,
    npcd_run = 2'b01,
    npcd_hold = 2'b10
  } npcd_state_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } npcd_bus_type;
endpackage

// ==== design/npcd_top.sv ====
// nonvolatile-memory program clock divider and sequencer
// Behaviour
// [RULE1] in burst mode the charge pump stays on between consecutive byte programs.
// [RULE2] an ordinary command turns the pump on at launch and off at completion.
// [RULE3] the loaded flag in bit 7 is read-only, cleared by reset, set by the first write.
// [RULE4] while the loaded flag is 0 every program or erase launch is refused.
// [RULE5] bit 6 selects bus clock or bus clock divided by 8 as divider input.
// [RULE6] the prescale bit takes only the first write after reset.
// [RULE7] bits 5:0 divide the selected input by the field value plus one.
// [RULE8] software keeps the divided clock between 150 and 200 kHz.
// [RULE9] each timing pulse lasts one period of the divided clock.
// [RULE10] the sequencer times every operation as a whole count of pulses.
// [RULE11] software launches a queued command by clearing the buffer-empty flag.
// [RULE12] the done flag is set when a launched command finishes.
// [RULE13] a reloading counter emits a one-cycle tick per wrap that paces the sequencer.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module npcd_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire npcd_pkg::npcd_bus_type bus,
  output logic [7:0] rdata,
  output logic pump_on,
  output logic pulse_tick
);
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [2:0] pre_cnt;
  logic [2:0] next_pre_cnt;
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic tick;
  logic next_tick;
  npcd_pkg::npcd_state_type state;
  npcd_pkg::npcd_state_type next_state;
  logic [7:0] len;
  logic [7:0] next_len;
  logic [7:0] pcount;
  logic [7:0] next_pcount;
  logic done;
  logic next_done;
  logic empty;
  logic next_empty;
  logic refused;
  logic next_refused;
  logic burst;
  logic next_burst;
  logic [7:0] next_rdata;
  logic next_pump;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire logic cfg_wr = bus.write && hit(bus.addr, npcd_pkg::cfg_offset);
  wire logic cmd_wr = bus.write && hit(bus.addr, npcd_pkg::cmd_offset);
  wire logic launch = cmd_wr && bus.wdata[npcd_pkg::launch_pos];

  // configuration register
  always_comb
  begin
    next_cfg = cfg;
    if (cfg_wr)
    begin
      // [RULE7] divisor always writable
      next_cfg[5:0] = bus.wdata[5:0];
      // [RULE6] prescale write once
      if (!cfg[npcd_pkg::loaded_pos])
        next_cfg[npcd_pkg::prescale_pos] = bus.wdata[npcd_pkg::prescale_pos];
      // [RULE3] first write sets loaded
      next_cfg[npcd_pkg::loaded_pos] = 1'b1;
    end
  end

  // [RULE3] flag stays set
  loaded_sticky_a: assert property ( // [RULE3]
    @(posedge clock) disable iff (!rst_n)
    cfg[npcd_pkg::loaded_pos] |=> cfg[npcd_pkg::loaded_pos])
    else $error("loaded flag dropped");
  // [RULE3] first write sets
  first_write_a: assert property ( // [RULE3]
    @(posedge clock) disable iff (!rst_n)
    cfg_wr |=> cfg[npcd_pkg::loaded_pos])
    else $error("first write missed");
  // [RULE6] prescale write once
  prescale_once_a: assert property ( // [RULE6]
    @(posedge clock) disable iff (!rst_n)
    cfg[npcd_pkg::loaded_pos]
      |=> cfg[npcd_pkg::prescale_pos] == $past(cfg[npcd_pkg::prescale_pos]))
    else $error("prescale rewritten");

  // divider chain
  always_comb
  begin
    logic pre_en;
    pre_en = 1'b1;
    next_pre_cnt = pre_cnt + 3'h1;
    // [RULE5] optional divide by eight
    if (cfg[npcd_pkg::prescale_pos])
      pre_en = (pre_cnt == npcd_pkg::prescale_last);
    next_div_cnt = div_cnt;
    next_tick = 1'b0;
    // [RULE13] reloading counter tick
    if (pre_en)
    begin
      if (div_cnt == 6'h00)
      begin
        // [RULE7] reload with field, n plus one periods
        next_div_cnt = cfg[5:0];
        next_tick = 1'b1;
      end
      else
        next_div_cnt = div_cnt - 6'h01;
    end
  end

  // [RULE13] tick one cycle
  tick_single_a: assert property ( // [RULE13]
    @(posedge clock) disable iff (!rst_n)
    tick && (div_cnt != 6'h00
      || (cfg[npcd_pkg::prescale_pos] && pre_cnt != npcd_pkg::prescale_last)) |=> !tick)
    else $error("tick too long");
  // [RULE7] reload from field
  div_reload_a: assert property ( // [RULE7]
    @(posedge clock) disable iff (!rst_n)
    next_tick |=> div_cnt == $past(cfg[5:0]))
    else $error("divider reload wrong");
  // [RULE5] divide by eight
  slow_tick_a: assert property ( // [RULE5]
    @(posedge clock) disable iff (!rst_n)
    tick && cfg[npcd_pkg::prescale_pos] && pre_cnt == 3'h0 |=> !tick [*7])
    else $error("prescale ignored");
  // [RULE9] no pulse mid period
  tick_gap_a: assert property ( // [RULE9]
    @(posedge clock) disable iff (!rst_n)
    !cfg[npcd_pkg::prescale_pos] && div_cnt != 6'h00 |=> !pulse_tick)
    else $error("pulse inside period");
  // [RULE7] pulse at wrap
  tick_due_a: assert property ( // [RULE7]
    @(posedge clock) disable iff (!rst_n)
    !cfg[npcd_pkg::prescale_pos] && div_cnt == 6'h00 |=> pulse_tick)
    else $error("pulse missing at wrap");

  // sequencer
  always_comb
  begin
    next_state = state;
    next_len = len;
    next_pcount = pcount;
    next_done = done;
    next_empty = empty;
    next_refused = refused;
    next_burst = burst;
    next_pump = pump_on;
    if (bus.write && hit(bus.addr, npcd_pkg::len_offset))
      next_len = bus.wdata;
    // done and refused cleared by writing one to status
    if (bus.write && hit(bus.addr, npcd_pkg::stat_offset))
    begin
      if (bus.wdata[npcd_pkg::done_pos])
        next_done = 1'b0;
      if (bus.wdata[npcd_pkg::refused_pos])
        next_refused = 1'b0;
    end
    case (state)
      npcd_pkg::npcd_idle, npcd_pkg::npcd_hold:
      begin
        // [RULE11] launch clears buffer-empty
        if (launch && empty)
        begin
          // [RULE4] refuse while not loaded
          if (!cfg[npcd_pkg::loaded_pos])
            next_refused = 1'b1;
          else
          begin
            next_empty = 1'b0;
            next_burst = bus.wdata[npcd_pkg::cmd_burst_pos];
            next_pcount = len;
            // [RULE2] pump on at launch
            next_pump = 1'b1;
            next_state = npcd_pkg::npcd_run;
          end
        end
        else if (state == npcd_pkg::npcd_hold && !launch)
        begin
          // burst ends when no next byte is queued
          next_pump = 1'b0;
          next_state = npcd_pkg::npcd_idle;
        end
      end
      npcd_pkg::npcd_run:
      begin
        // [RULE10] whole count of pulses
        if (tick)
        begin
          if (pcount <= 8'h01)
          begin
            // [RULE12] completion flag
            next_done = 1'b1;
            next_empty = 1'b1;
            // [RULE1] burst keeps pump on
            if (burst)
              next_state = npcd_pkg::npcd_hold;
            else
            begin
              next_pump = 1'b0;
              next_state = npcd_pkg::npcd_idle;
            end
          end
          else
            next_pcount = pcount - 8'h01;
        end
      end
      default:
        next_state = npcd_pkg::npcd_idle;
    endcase
  end

  // [RULE4] refuse when unloaded
  refuse_unloaded_a: assert property ( // [RULE4]
    @(posedge clock) disable iff (!rst_n)
    launch && !cfg[npcd_pkg::loaded_pos] |=> state == npcd_pkg::npcd_idle && refused)
    else $error("launch not refused");
  // [RULE2] pump on launch
  pump_launch_a: assert property ( // [RULE2]
    @(posedge clock) disable iff (!rst_n)
    launch && cfg[npcd_pkg::loaded_pos] && empty && state != npcd_pkg::npcd_run |=> pump_on)
    else $error("pump not on");
  // [RULE2] pump off done
  pump_off_a: assert property ( // [RULE2]
    @(posedge clock) disable iff (!rst_n)
    state == npcd_pkg::npcd_run && tick && pcount <= 8'h01 && !burst
      |=> !pump_on && state == npcd_pkg::npcd_idle)
    else $error("pump left on");
  // [RULE1] burst keeps pump
  burst_hold_a: assert property ( // [RULE1]
    @(posedge clock) disable iff (!rst_n)
    state == npcd_pkg::npcd_run && tick && pcount <= 8'h01 && burst |=> pump_on && done)
    else $error("burst pump dropped");
  // [RULE1] burst end drops
  hold_exit_a: assert property ( // [RULE1]
    @(posedge clock) disable iff (!rst_n)
    state == npcd_pkg::npcd_hold && !launch |=> !pump_on && state == npcd_pkg::npcd_idle)
    else $error("burst pump stuck");
  // [RULE12] done on completion
  done_set_a: assert property ( // [RULE12]
    @(posedge clock) disable iff (!rst_n)
    state == npcd_pkg::npcd_run && tick && pcount <= 8'h01 |=> done && empty)
    else $error("done not set");
  // [RULE10] one count per pulse
  pcount_step_a: assert property ( // [RULE10]
    @(posedge clock) disable iff (!rst_n)
    state == npcd_pkg::npcd_run && tick && pcount > 8'h01
      |=> pcount == $past(pcount) - 8'h01)
    else $error("pulse count step wrong");

  // read mux, one cycle later
  always_comb
  begin
    next_rdata = 8'h00;
    if (bus.read)
    begin
      if (hit(bus.addr, npcd_pkg::cfg_offset))
        next_rdata = cfg;
      else if (hit(bus.addr, npcd_pkg::stat_offset))
        next_rdata = {3'h0, burst, refused, pump_on, empty, done};
      else if (hit(bus.addr, npcd_pkg::len_offset))
        next_rdata = len;
      else
        next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= npcd_pkg::cfg_reset;
      pre_cnt <= 3'h0;
      div_cnt <= npcd_pkg::div_reset;
      tick <= 1'b0;
      pulse_tick <= 1'b0;
      state <= npcd_pkg::npcd_idle;
      len <= npcd_pkg::len_reset;
      pcount <= 8'h00;
      done <= 1'b0;
      empty <= 1'b1;
      refused <= 1'b0;
      burst <= 1'b0;
      pump_on <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      cfg <= next_cfg;
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      // [RULE9] pulse marks one divided period
      pulse_tick <= next_tick;
      state <= next_state;
      len <= next_len;
      pcount <= next_pcount;
      // [RULE12] set wins over clear
      done <= next_done;
      empty <= next_empty;
      refused <= next_refused;
      burst <= next_burst;
      pump_on <= next_pump;
      rdata <= next_rdata;
    end
  end

endmodule // npcd_top
`default_nettype wire

// ==== tb/npcd_top_test.sv ====
// register-level bench for the program clock divider
`timescale 1ns/10ps
`default_nettype none
module npcd_top_test;
  logic clock;
  logic rst_n;
  npcd_pkg::npcd_bus_type bus;
  logic [7:0] rdata;
  logic pump_on;
  logic pulse_tick;
  int fail_count;
  int comparisons;
  logic [7:0] got;
  int n;
  npcd_top dut (
    .clock(clock),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .pump_on(pump_on),
    .pulse_tick(pulse_tick)
  );
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic drive(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, write: w, read: r};
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    drive(a, d, 1'b1, 1'b0);
    drive(a, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    drive(a, 8'h00, 1'b0, 1'b1);
    drive(a, 8'h00, 1'b0, 1'b0);
    #1 d = rdata;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // cycles until the next divider tick
  task automatic wait_tick(output int c);
    c = 0;
    do
    begin
      @(posedge clock);
      #1 c++;
    end while (pulse_tick !== 1'b1 && c < 2000);
    if (c >= 2000)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic period(input logic [7:0] exp);
    wait_tick(n);
    wait_tick(n);
    chk("tick period", exp, n[7:0]);
  endtask
  // ticks seen while the pump is on
  task automatic pump_ticks(output int t);
    int c;
    t = 0;
    c = 0;
    // look after the launch edge has settled
    #1;
    while (pump_on !== 1'b1 && c < 3)
    begin
      @(posedge clock);
      #1 c++;
    end
    chk("pump raised", 8'h01, {7'h00, pump_on});
    while (pump_on === 1'b1 && c < 2000)
    begin
      if (pulse_tick === 1'b1)
        t++;
      @(posedge clock);
      #1 c++;
    end
    if (c >= 2000)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  initial
  begin
    #5000000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    fail_count = 0;
    comparisons = 0;
    do_reset();
    rd(npcd_pkg::cfg_offset, got);
    chk("cfg reset", npcd_pkg::cfg_reset, got);
    rd(npcd_pkg::len_offset, got);
    chk("len reset", npcd_pkg::len_reset, got);
    rd(4'h9, got);
    chk("unmapped", 8'h00, got);
    @(posedge clock);
    #1 chk("idle rdata", 8'h00, rdata);
    wr(npcd_pkg::cmd_offset, 8'h80);
    repeat (3) @(posedge clock);
    #1 chk("pump refused", 8'h00, {7'h00, pump_on});
    rd(npcd_pkg::stat_offset, got);
    chk("refused", 8'h0a, got);
    wr(npcd_pkg::stat_offset, 8'h09);
    rd(npcd_pkg::stat_offset, got);
    chk("refused clear", 8'h02, got);
    $display("test refusal done");
    wr(npcd_pkg::cfg_offset, 8'h41);
    rd(npcd_pkg::cfg_offset, got);
    chk("cfg first", 8'hc1, got);
    // divided clock 156 kHz
    wr(npcd_pkg::cfg_offset, 8'h07);
    rd(npcd_pkg::cfg_offset, got);
    chk("cfg second", 8'hc7, got);
    period(8'd64);
    $display("test prescale done");
    do_reset();
    rd(npcd_pkg::cfg_offset, got);
    chk("cfg after reset", npcd_pkg::cfg_reset, got);
    // divided clock 179 kHz
    wr(npcd_pkg::cfg_offset, 8'h37);
    rd(npcd_pkg::cfg_offset, got);
    chk("cfg plain", 8'hb7, got);
    period(8'd56);
    $display("test divisor done");
    wr(npcd_pkg::len_offset, 8'h02);
    rd(npcd_pkg::len_offset, got);
    chk("len written", 8'h02, got);
    wr(npcd_pkg::cmd_offset, 8'h80);
    pump_ticks(n);
    chk("pulse count", 8'd2, n[7:0]);
    rd(npcd_pkg::stat_offset, got);
    chk("status done", 8'h03, got);
    $display("test normal done");
    // strobe held high: a burst launch offered every cycle, taken each time the sequencer reaches hold, back to back
    drive(npcd_pkg::cmd_offset, 8'h81, 1'b1, 1'b0);
    @(posedge clock);
    n = 0;
    repeat (250)
    begin
      @(posedge clock);
      #1 if (pump_on !== 1'b1) n++;
    end
    chk("burst pump gaps", 8'h00, n[7:0]);
    drive(npcd_pkg::cmd_offset, 8'h00, 1'b0, 1'b0);
    repeat (250) @(posedge clock);
    #1 chk("burst pump off", 8'h00, {7'h00, pump_on});
    $display("test burst done");
    tally_and_finish();
  end
endmodule // npcd_top_test
`default_nettype wire
